//--- rtl/resistor_baseline_validator.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Any sample at or below 40F invalidates
// - Drop over 6F from previous invalidates
// - Invalid first attempt triggers one automatic retry
// - Interrupted attempt also triggers the retry
// - No upper temperature limit is applied
// - Invalid status only after two failed attempts
// - After invalid, wait for new calibration request
// - Pending while cooling or battery below 13V
// - Pending or invalid selects interim integrity test
// - Twenty minute cool, then eight minute sampling
// - Retry starts twenty minutes later, still pending
// - Success sets valid, baseline test applies
module resistor_baseline_validator
  import baseline_pkg::*;
#(
  parameter int unsigned  SCANNERS       = 4,
  parameter longint unsigned COOL_CYCLES   = 64'(COOL_WAIT_MIN) * CYCLES_PER_MIN,
  parameter longint unsigned SAMPLE_CYCLES = 64'(SAMPLE_MIN) * CYCLES_PER_MIN,
  parameter longint unsigned RETRY_CYCLES  = 64'(RETRY_MIN) * CYCLES_PER_MIN
) (
  // Clock, reset and enable
  input  wire logic                        clock_i,
  input  wire logic                        reset_n_i,
  input  wire logic                        enable_i,
  // Control
  input  wire logic                        calibration_done_i,
  input  wire logic                        interrupt_i,
  input  wire logic [15:0]                 battery_dv_i,
  // Samples
  input  wire baseline_pkg::sample_type    sample_i,
  // Status
  output logic [SCANNERS-1:0][1:0]         status_o,
  output logic [SCANNERS-1:0]              interim_test_o,
  output logic                             shutter_cycle_o,
  output logic                             attempt_second_o
);
  import baseline_pkg::*;

  // One-hot attempt phases
  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0001,
    ST_COOL     = 4'b0010,
    ST_SAMPLE   = 4'b0100,
    ST_DONE     = 4'b1000
  } phase_type;

  phase_type                    phase_q;
  // Wide enough for minutes at the full clock rate
  logic [63:0]                  timer_q;
  logic                         second_q;
  logic [SCANNERS-1:0]          bad_q;
  logic [SCANNERS-1:0]          bad_now;
  logic [SCANNERS-1:0]          seen_q;
  logic signed [TEMP_W-1:0]     last_q [SCANNERS];
  logic [SCANNERS-1:0][1:0]     status_q;

  logic battery_ok;
  logic timer_end;
  logic attempt_end;
  logic any_bad;
  assign battery_ok  = battery_dv_i >= BATTERY_MIN_DV;
  assign timer_end   = timer_q == 64'h0;
  // Retry is shared: one failing scanner re-runs them all
  assign any_bad     = |bad_now;
  assign attempt_end = (phase_q == ST_SAMPLE) && timer_end;

  // Attempt sequencer
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_q  <= ST_IDLE;
      timer_q  <= 64'h0;
      second_q <= 1'b0;
    end else if (enable_i) begin
      case (phase_q)
        ST_IDLE: begin
          if (calibration_done_i) begin
            phase_q  <= ST_COOL;
            timer_q  <= COOL_CYCLES;
            second_q <= 1'b0;
          end
        end
        ST_COOL: begin
          // Hold countdown at zero until battery is charged
          if (!timer_end) begin
            timer_q <= timer_q - 64'h1;
          end else if (battery_ok) begin
            phase_q <= ST_SAMPLE;
            timer_q <= SAMPLE_CYCLES;
          end
        end
        ST_SAMPLE: begin
          // Interrupt wins over a verdict on the same edge
          if (interrupt_i || (timer_end && any_bad)) begin
            if (second_q) begin
              phase_q <= ST_DONE;
            end else begin
              phase_q  <= ST_COOL;
              timer_q  <= RETRY_CYCLES;
              second_q <= 1'b1;
            end
          end else if (timer_end) begin
            phase_q <= ST_DONE;
          end else begin
            timer_q <= timer_q - 64'h1;
          end
        end
        ST_DONE: begin
          // No own retries; only a new calibration restarts
          if (calibration_done_i) begin
            phase_q  <= ST_COOL;
            timer_q  <= COOL_CYCLES;
            second_q <= 1'b0;
          end
        end
        default: phase_q <= ST_IDLE;
      endcase
    end
  end

  // Per-scanner sample checks
  genvar g;
  generate
    for (g = 0; g < SCANNERS; g++) begin : g_scan
      logic hit;
      logic floor_hit;
      logic drop_hit;
      assign hit = sample_i.valid && (32'(sample_i.scanner) == g) && (phase_q == ST_SAMPLE);
      // Upper end deliberately unchecked
      assign floor_hit = hit && (sample_i.temp <= FLOOR_TEMP_F);
      // First sample of an attempt has nothing to step from
      assign drop_hit  = hit && seen_q[g] && (sample_i.temp < last_q[g] - MAX_DROP_F);
      // Sample landing on the closing cycle still counts
      assign bad_now[g] = bad_q[g] || floor_hit || drop_hit;

      // Failure flag, cleared outside the window
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          bad_q[g] <= 1'b0;
        end else if (enable_i) begin
          if (phase_q != ST_SAMPLE) begin
            bad_q[g] <= 1'b0;
          end else if (!interrupt_i && (floor_hit || drop_hit)) begin
            bad_q[g] <= 1'b1;
          end
        end
      end

      // Previous sample for the step test
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          seen_q[g] <= 1'b0;
          last_q[g] <= '0;
        end else if (enable_i) begin
          if (phase_q != ST_SAMPLE) begin
            seen_q[g] <= 1'b0;
          end else if (hit && !interrupt_i) begin
            seen_q[g] <= 1'b1;
            last_q[g] <= sample_i.temp;
          end
        end
      end

      // Valid on a first pass lasts only until the retry cools

      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          status_q[g] <= STATUS_PENDING;
        end else if (enable_i) begin
          if (phase_q == ST_COOL) begin
            status_q[g] <= STATUS_PENDING;
          end else if (attempt_end && !interrupt_i) begin
            if (!bad_now[g]) begin
              status_q[g] <= STATUS_VALID;
            end else if (second_q) begin
              status_q[g] <= STATUS_INVALID;
            end
          end else if (phase_q == ST_SAMPLE && interrupt_i && second_q) begin
            status_q[g] <= STATUS_INVALID;
          end
        end
      end


      // Same latency as status_o, so both ports agree every cycle
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          interim_test_o[g] <= 1'b1;
        end else if (enable_i) begin
          interim_test_o[g] <= status_q[g] != STATUS_VALID;
        end
      end
    end
  endgenerate

  // Registered copies keep every port free of decode glitches
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_o         <= '0;
      shutter_cycle_o  <= 1'b0;
      attempt_second_o <= 1'b0;
    end else if (enable_i) begin
      status_o         <= status_q;
      shutter_cycle_o  <= phase_q == ST_SAMPLE;
      attempt_second_o <= second_q;
    end
  end

endmodule // resistor_baseline_validator

`default_nettype wire

//--- rtl/baseline_pkg.sv
package baseline_pkg;

  // Temperatures in whole degrees Fahrenheit, signed
  localparam int TEMP_W = 12;
  localparam logic signed [TEMP_W-1:0] FLOOR_TEMP_F = 12'sh028;  // 40 F
  localparam logic signed [TEMP_W-1:0] MAX_DROP_F   = 12'sh006;  // 6 F
  localparam logic [15:0] BATTERY_MIN_DV = 16'h0082;              // 13.0 V in tenths

  localparam int unsigned CLOCK_HZ      = 100_000_000;
  localparam int unsigned COOL_WAIT_MIN = 20;
  localparam int unsigned SAMPLE_MIN    = 8;
  localparam int unsigned RETRY_MIN     = 20;
  localparam longint unsigned CYCLES_PER_MIN = 64'(CLOCK_HZ) * 64'd60;

  typedef enum logic [1:0] {
    STATUS_PENDING = 2'h0,
    STATUS_VALID   = 2'h1,
    STATUS_INVALID = 2'h2
  } status_type;

  typedef struct packed {
    logic                     valid;
    logic [3:0]               scanner;
    logic signed [TEMP_W-1:0] temp;
  } sample_type;

endpackage : baseline_pkg

//--- verif/resistor_baseline_validator_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module resistor_baseline_validator_monitor
  import baseline_pkg::*;
#(parameter int unsigned SCANNERS = 4) (
  // Clock and control
  input wire logic                     clock_i,
  input wire logic                     reset_n_i,
  input wire logic                     enable_i,
  input wire logic                     calibration_done_i,
  input wire logic                     interrupt_i,
  input wire logic [15:0]              battery_dv_i,
  input wire baseline_pkg::sample_type sample_i,
  // Design outputs
  input wire logic [SCANNERS-1:0][1:0] status_o,
  input wire logic [SCANNERS-1:0]      interim_test_o,
  input wire logic                     shutter_cycle_o,
  input wire logic                     attempt_second_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_interim;
    interim_test_o[0] == (status_o[0] != STATUS_VALID);
  endproperty
  a_interim: assert property (p_interim) else $error("interim select");
  property p_pend;
    shutter_cycle_o |-> status_o[0] == STATUS_PENDING;
  endproperty
  a_pend: assert property (p_pend) else $error("not pending");
  property p_batt;
    $rose(shutter_cycle_o) |-> $past(battery_dv_i) >= BATTERY_MIN_DV;
  endproperty
  a_batt: assert property (p_batt) else $error("low battery");
  property p_len;
    $rose(shutter_cycle_o) |-> shutter_cycle_o[*8];
  endproperty
  a_len: assert property (p_len) else $error("short window");
  property p_chg;
    $changed(status_o) |-> !shutter_cycle_o;
  endproperty
  a_chg: assert property (p_chg) else $error("early verdict");
  property p_inv;
    status_o[0] == STATUS_INVALID |-> !shutter_cycle_o;
  endproperty
  a_inv: assert property (p_inv) else $error("sampled while invalid");
  property p_v2i;
    $past(status_o[0]) == STATUS_VALID |-> status_o[0] != STATUS_INVALID;
  endproperty
  a_v2i: assert property (p_v2i) else $error("invalid in one try");
  property p_retry;
    $rose(attempt_second_o) |-> !shutter_cycle_o;
  endproperty
  a_retry: assert property (p_retry) else $error("retry mid window");
endmodule // resistor_baseline_validator_monitor
bind resistor_baseline_validator resistor_baseline_validator_monitor
  #(.SCANNERS(SCANNERS)) mon_u (.*);
`default_nettype wire

//--- verif/scanner_feed_model.sv
`timescale 1ns/1ps
`default_nettype none
module scanner_feed_model
  import baseline_pkg::*;
(
  input wire logic                    clock_i,
  input wire logic                    shutter_i,
  input wire logic [1:0]              mode_i,
  output var baseline_pkg::sample_type sample_o
);
  import baseline_pkg::*;
  logic [4:0] n_q;
  logic [3:0] k;
  assign k = n_q[4:1];
  // Scanners interleaved, each in acquisition order
  always_ff @(posedge clock_i) begin
    n_q <= shutter_i ? n_q + 5'h01 : 5'h00;
    sample_o.valid <= shutter_i;
    sample_o.scanner <= {3'h0, n_q[0]};
    if (!shutter_i)
      sample_o.temp <= ~sample_o.temp;
    else if (!n_q[0])
      sample_o.temp <= (mode_i == 2'h3) ? 12'sd301 : 12'sd100;
    else
      case (mode_i)
        2'h1: sample_o.temp <= 12'sd40;
        2'h2: sample_o.temp <= 12'sd100 - 12'(7 * k);
        2'h3: sample_o.temp <= 12'sd100 - 12'(6 * k);
        default: sample_o.temp <= 12'sd100;
      endcase
  end
endmodule // scanner_feed_model
`default_nettype wire

//--- verif/resistor_baseline_validator_bench.sv
`timescale 1ns/1ps
`default_nettype none
module resistor_baseline_validator_bench;
  import baseline_pkg::*;
  logic clk = 0, rst_n = 0, cal = 0, intr = 0, shut, sec;
  logic [15:0] bat = 16'h0082;
  logic [1:0] mode = 0, itst;
  logic [1:0][1:0] st;
  sample_type smp;
  int num_errors = 0, tests_run = 0, cyc = 0;
  always #5 clk = ~clk;
  resistor_baseline_validator #(.SCANNERS(2), .COOL_CYCLES(10),
    .SAMPLE_CYCLES(20), .RETRY_CYCLES(10)) dut_u (.clock_i(clk),
    .reset_n_i(rst_n), .enable_i(1'b1), .calibration_done_i(cal),
    .interrupt_i(intr), .battery_dv_i(bat), .sample_i(smp), .status_o(st),
    .interim_test_o(itst), .shutter_cycle_o(shut), .attempt_second_o(sec));
  scanner_feed_model feed_u (.clock_i(clk), .shutter_i(shut), .mode_i(mode),
    .sample_o(smp));
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string s, input logic [3:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task calib();
    cal = 1;
    tick(1);
    cal = 0;
  endtask
  task attempt(input logic [1:0] m, input logic i);
    int n;
    mode = m;
    for (n = 0; n < 300 && !shut; n++) tick(1);
    if (i) tick(10);
    intr = i;
    for (n = 0; n < 300 && shut; n++) tick(1);
    intr = 0;
    tick(4);
  endtask
  task t_valid();
    calib();
    attempt(3, 0);
    chk("status", {STATUS_VALID, STATUS_VALID}, st);
    chk("interim", 4'h0, {2'h0, itst});
  endtask
  task t_floor();
    calib();
    attempt(1, 0);
    chk("second", 4'h1, {3'h0, sec});
    chk("status1", 4'h0, {2'h0, st[1]});
    attempt(1, 0);
    chk("status", {STATUS_INVALID, STATUS_VALID}, st);
    chk("interim", 4'h2, {2'h0, itst});
    tick(60);
    chk("idle", {STATUS_INVALID, 1'b0, 1'b0}, {st[1], 1'b0, shut});
  endtask
  task t_drop();
    calib();
    attempt(2, 0);
    attempt(2, 0);
    chk("status1", {2'h0, STATUS_INVALID}, {2'h0, st[1]});
  endtask
  task t_intr();
    calib();
    attempt(0, 1);
    chk("second", 4'h1, {3'h0, sec});
    attempt(0, 1);
    chk("status", {STATUS_INVALID, STATUS_INVALID}, st);
  endtask
  task t_batt();
    bat = 16'h0081;
    calib();
    tick(40);
    chk("wait", {STATUS_PENDING, STATUS_PENDING}, st | {3'h0, shut});
    bat = 16'h0082;
    attempt(0, 0);
    chk("status", {STATUS_VALID, STATUS_VALID}, st);
  endtask
  task give_verdict();
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    tick(20);
    rst_n = 1;
    tick(1);
    t_valid();
    t_floor();
    t_drop();
    t_intr();
    t_batt();
    give_verdict();
  end
endmodule // resistor_baseline_validator_bench
`default_nettype wire
